// File: src/island_image_pkg.sv
package island_image_pkg;
	localparam int ADDR_W          = 16;
	localparam int DATA_W          = 16;
	localparam int BASE_CHANNELS   = 12;
	localparam int BASE_IN_REG     = 0;
	localparam int FIRST_EXP_IN    = 1;
	localparam int LAST_IN_REG     = 32;
	localparam int BASE_OUT_REG    = 100;
	localparam int FIRST_EXP_OUT   = 101;
	localparam int LAST_OUT_REG    = 128;
	localparam int EXP_IN_MAX      = LAST_IN_REG - FIRST_EXP_IN + 1;
	localparam int EXP_OUT_MAX     = LAST_OUT_REG - FIRST_EXP_OUT + 1;
	localparam int IN_CNT_W        = 6;
	localparam int OUT_CNT_W       = 5;
	localparam logic [DATA_W-1:0] OUT_RESET = 16'h0000;
	localparam int SYNC_W = BASE_CHANNELS + EXP_IN_MAX * DATA_W + IN_CNT_W + OUT_CNT_W;
endpackage

// File: src/sync_if.sv
`timescale 1ns/1ns
interface sync_if #(parameter int WIDTH = 1);
	logic [WIDTH-1:0] raw;
	logic [WIDTH-1:0] safe;
	modport sink (input raw, output safe);
	modport user (output raw, input safe);
endinterface

// File: src/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic i_clock,
	input  wire logic i_sys_rst,
	sync_if.sink      port
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] held;
	} sync_state_t;

	sync_state_t s_q;
	sync_state_t s_d;

	always_comb begin
		s_d.meta = port.raw;
		s_d.held = s_q.meta;
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign port.safe = s_q.held;
endmodule

// File: src/island_io_image_registers.sv
`timescale 1ns/1ns
module island_io_image_registers (
	input  wire logic                                    i_clock,
	input  wire logic                                    i_sys_rst,
	input  wire logic                                    i_req,
	input  wire logic                                    i_write,
	input  wire logic [island_image_pkg::ADDR_W-1:0]     i_addr,
	input  wire logic [island_image_pkg::DATA_W-1:0]     i_wdata,
	output logic                                         o_ack,
	output logic                                         o_err,
	output logic      [island_image_pkg::DATA_W-1:0]     o_rdata,
	input  wire logic [island_image_pkg::BASE_CHANNELS-1:0] i_base_inputs,
	input  wire logic [island_image_pkg::EXP_IN_MAX*island_image_pkg::DATA_W-1:0] i_exp_inputs,
	input  wire logic [island_image_pkg::IN_CNT_W-1:0]   i_exp_in_count,
	input  wire logic [island_image_pkg::OUT_CNT_W-1:0]  i_exp_out_count,
	output logic      [island_image_pkg::BASE_CHANNELS-1:0] o_base_outputs,
	output logic [island_image_pkg::EXP_OUT_MAX*island_image_pkg::DATA_W-1:0] o_exp_outputs
);
	import island_image_pkg::*;

	// slot index widths of the two expansion zones
	localparam int IN_SLOT_W  = $clog2(EXP_IN_MAX);
	localparam int OUT_SLOT_W = $clog2(EXP_OUT_MAX);

	typedef struct packed {
		logic [DATA_W-1:0]                  base_out;
		logic [EXP_OUT_MAX-1:0][DATA_W-1:0] exp_out;
		logic [DATA_W-1:0]                  rdata;
		logic                               ack;
		logic                               err;
		logic [IN_CNT_W-1:0]                in_cnt_prev;
		logic [IN_CNT_W-1:0]                in_cnt_ok;
		logic [OUT_CNT_W-1:0]               out_cnt_prev;
		logic [OUT_CNT_W-1:0]               out_cnt_ok;
	} image_state_t;

	image_state_t                      s_q;
	image_state_t                      s_d;
	logic [BASE_CHANNELS-1:0]          base_in;
	logic [EXP_IN_MAX-1:0][DATA_W-1:0] exp_in;
	logic [IN_CNT_W-1:0]               in_cnt;
	logic [OUT_CNT_W-1:0]              out_cnt;

	// request decode and presence
	logic                              hit_base_in;
	logic                              hit_exp_in;
	logic                              hit_base_out;
	logic                              hit_exp_out;
	logic                              hit_any;
	logic [IN_SLOT_W-1:0]              in_slot;
	logic [OUT_SLOT_W-1:0]             out_slot;
	logic [EXP_IN_MAX-1:0]             in_mask;
	logic [EXP_OUT_MAX-1:0]            out_mask;
	logic [EXP_IN_MAX-1:0]             in_sel;
	logic [EXP_OUT_MAX-1:0]            out_sel;
	logic                              in_present;
	logic                              out_present;
	logic                              in_cnt_same;
	logic                              out_cnt_same;
	logic                              bad_write;
	logic                              bad_in;
	logic                              bad_out;
	logic                              bad_addr;
	logic                              refuse;
	logic                              rd_ok;
	logic                              wr_base;
	logic [EXP_OUT_MAX-1:0]            wr_slot;
	logic [DATA_W-1:0]                 in_word;
	logic [DATA_W-1:0]                 out_word;
	logic [DATA_W-1:0]                 rd_word;

	sync_if #(.WIDTH(SYNC_W)) pins ();

	// island inputs and presence counts come from outside the clock domain
	assign pins.raw = {i_base_inputs, i_exp_inputs, i_exp_in_count, i_exp_out_count};
	assign {base_in, exp_in, in_cnt, out_cnt} = pins.safe;

	pin_sync #(.WIDTH(SYNC_W)) u_sync (
		.i_clock   (i_clock),
		.i_sys_rst (i_sys_rst),
		.port      (pins)
	);

	// zone decode of the requested register number
	always_comb begin
		int addr;
		int in_off;
		int out_off;
		addr         = int'(i_addr);
		in_off       = addr - FIRST_EXP_IN;
		out_off      = addr - FIRST_EXP_OUT;
		hit_base_in  = (addr == BASE_IN_REG);
		hit_exp_in   = (addr >= FIRST_EXP_IN) && (addr <= LAST_IN_REG);
		hit_base_out = (addr == BASE_OUT_REG);
		hit_exp_out  = (addr >= FIRST_EXP_OUT) && (addr <= LAST_OUT_REG);
		hit_any      = hit_base_in || hit_exp_in || hit_base_out || hit_exp_out;
		in_slot      = '0;
		out_slot     = '0;
		if (hit_exp_in) begin
			in_slot = IN_SLOT_W'(in_off);
		end
		if (hit_exp_out) begin
			out_slot = OUT_SLOT_W'(out_off);
		end
	end

	// a count is taken once two successive samples agree, so a count caught
	// mid-change never opens a slot that is not fitted
	always_comb begin
		in_cnt_same  = (in_cnt == s_q.in_cnt_prev);
		out_cnt_same = (out_cnt == s_q.out_cnt_prev);
	end

	// slots are packed left to right by the island, so the first count slots
	// are the modules actually fitted
	for (genvar k = 0; k < EXP_IN_MAX; k++) begin : g_in_slot
		assign in_mask[k] = (int'(s_q.in_cnt_ok) > k);
		assign in_sel[k]  = hit_exp_in && (int'(in_slot) == k);
	end

	// output slots: presence, selection and the per-slot write strobe
	for (genvar k = 0; k < EXP_OUT_MAX; k++) begin : g_out_slot
		assign out_mask[k] = (int'(s_q.out_cnt_ok) > k);
		assign out_sel[k]  = hit_exp_out && (int'(out_slot) == k);
		assign wr_slot[k]  = i_req && i_write && out_sel[k] && out_mask[k];
	end

	// refusal reasons; any of them leaves the output image and the read data untouched
	always_comb begin
		in_present  = |(in_sel & in_mask);
		out_present = |(out_sel & out_mask);
		bad_write   = i_write && (hit_base_in || hit_exp_in);
		bad_in      = hit_exp_in && !in_present;
		bad_out     = hit_exp_out && !out_present;
		bad_addr    = !hit_any;
		refuse      = i_req && (bad_write || bad_in || bad_out || bad_addr);
		rd_ok       = i_req && !i_write && !refuse;
		wr_base     = i_req && i_write && hit_base_out;
	end

	// one-hot and-or selection keeps the wide slot muxes shallow
	always_comb begin
		in_word = '0;
		for (int k = 0; k < EXP_IN_MAX; k++) begin
			if (in_sel[k]) begin
				in_word = in_word | exp_in[k];
			end
		end
	end

	always_comb begin
		out_word = '0;
		for (int k = 0; k < EXP_OUT_MAX; k++) begin
			if (out_sel[k]) begin
				out_word = out_word | s_q.exp_out[k];
			end
		end
	end

	// read data of the addressed zone; the register holds when nothing readable is hit
	always_comb begin
		rd_word = s_q.rdata;
		if (hit_base_in) begin
			rd_word = {{(DATA_W-BASE_CHANNELS){1'b0}}, base_in};
		end else if (hit_exp_in) begin
			rd_word = in_word;
		end else if (hit_base_out) begin
			rd_word = s_q.base_out;
		end else if (hit_exp_out) begin
			rd_word = out_word;
		end
	end

	// every request is answered one cycle later, refused ones with the error flag too
	always_comb begin
		s_d              = s_q;
		s_d.ack          = i_req;
		s_d.err          = refuse;
		s_d.in_cnt_prev  = in_cnt;
		s_d.out_cnt_prev = out_cnt;
		if (in_cnt_same) begin
			s_d.in_cnt_ok = in_cnt;
		end
		if (out_cnt_same) begin
			s_d.out_cnt_ok = out_cnt;
		end
		if (rd_ok) begin
			s_d.rdata = rd_word;
		end
		if (wr_base) begin
			s_d.base_out = {{(DATA_W-BASE_CHANNELS){1'b0}},
				i_wdata[BASE_CHANNELS-1:0]};
		end
		for (int k = 0; k < EXP_OUT_MAX; k++) begin
			if (wr_slot[k]) begin
				s_d.exp_out[k] = i_wdata;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			s_q.base_out <= OUT_RESET;
			s_q.exp_out  <= {EXP_OUT_MAX{OUT_RESET}};
			s_q.rdata    <= '0;
			s_q.ack      <= 1'b0;
			s_q.err      <= 1'b0;
			// counts restart empty so no slot opens before the pins have settled
			s_q.in_cnt_prev  <= '0;
			s_q.in_cnt_ok    <= '0;
			s_q.out_cnt_prev <= '0;
			s_q.out_cnt_ok   <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_ack          = s_q.ack;
	assign o_err          = s_q.err;
	assign o_rdata        = s_q.rdata;
	assign o_base_outputs = s_q.base_out[BASE_CHANNELS-1:0];
	assign o_exp_outputs  = s_q.exp_out;
endmodule

// File: bench/island_checker_asserts.sv
`timescale 1ns/1ns
module island_checker import island_image_pkg::*; (
	input wire logic                     i_clock,
	input wire logic                     i_sys_rst,
	input wire logic                     i_req,
	input wire logic                     i_write,
	input wire logic [ADDR_W-1:0]        i_addr,
	input wire logic [DATA_W-1:0]        i_wdata,
	input wire logic                     o_ack,
	input wire logic                     o_err,
	input wire logic [DATA_W-1:0]        o_rdata,
	input wire logic [BASE_CHANNELS-1:0] o_base_outputs
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_sys_rst);
	sequence s_refuse; o_ack && o_err; endsequence
	property p_ack; i_req |=> o_ack; endproperty
	a_ack: assert property (p_ack) else $error("no answer");
	property p_idle; !i_req |=> !o_ack && !o_err; endproperty
	a_idle: assert property (p_idle) else $error("stray answer");
	property p_gap; i_req && i_addr > 16'h20 && i_addr < 16'h64 |=> s_refuse; endproperty
	a_gap: assert property (p_gap) else $error("gap taken");
	property p_high; i_req && i_addr > 16'h80 |=> s_refuse; endproperty
	a_high: assert property (p_high) else $error("high taken");
	property p_ro; i_req && i_write && i_addr <= 16'h20 |=> s_refuse; endproperty
	a_ro: assert property (p_ro) else $error("input written");
	property p_base; i_req && !i_write && i_addr == 16'h0 |=> !o_err && o_rdata[15:12] == 4'h0; endproperty
	a_base: assert property (p_base) else $error("base read");
	property p_bw;
		i_req && i_write && i_addr == 16'h64 |=> {4'h0, o_base_outputs} == ($past(i_wdata) & 16'h0fff);
	endproperty
	a_bw: assert property (p_bw) else $error("base write");
	property p_keep; o_err |-> $stable(o_base_outputs) && $stable(o_rdata); endproperty
	a_keep: assert property (p_keep) else $error("refused changed");
endmodule

// File: bench/net_master.sv
`timescale 1ns/1ns
module net_master import island_image_pkg::*; (
	input  wire logic              i_clock,
	input  wire logic              i_ack,
	input  wire logic              i_err,
	input  wire logic [DATA_W-1:0] i_rdata,
	output logic                   o_req = 1'b0,
	output logic                   o_write = 1'b0,
	output logic      [ADDR_W-1:0] o_addr = 16'h0,
	output logic      [DATA_W-1:0] o_wdata = 16'h0
);
	task automatic xfer(input logic w, input logic [15:0] a, d, output logic [15:0] r,
		output logic [1:0] e);
		@(posedge i_clock);
		{o_req, o_write, o_addr, o_wdata} <= {1'b1, w, a, d};
		@(posedge i_clock);
		{o_req, o_addr, o_wdata} <= {1'b0, ~a, ~d};
		@(posedge i_clock);
		r = i_rdata;
		e = {i_ack, i_err};
	endtask
endmodule

// File: bench/island_io_image_registers_tb.sv
`timescale 1ns/1ns
module island_io_image_registers_tb;
	import island_image_pkg::*;
	logic i_clock = 0, i_sys_rst = 1, i_req, i_write, o_ack, o_err;
	logic [15:0] i_addr, i_wdata, o_rdata, r;
	logic [1:0] e;
	logic [11:0] i_base_inputs, o_base_outputs;
	logic [511:0] i_exp_inputs;
	logic [447:0] o_exp_outputs;
	logic [5:0] i_exp_in_count;
	logic [4:0] i_exp_out_count;
	int fail_count = 0, tests_run = 0;
	island_io_image_registers u_island_io_image_registers (.i_clock, .i_sys_rst, .i_req,
		.i_write, .i_addr, .i_wdata, .o_ack, .o_err, .o_rdata, .i_base_inputs, .i_exp_inputs,
		.i_exp_in_count, .i_exp_out_count, .o_base_outputs, .o_exp_outputs);
	net_master u_net_master (.i_clock, .i_ack(o_ack), .i_err(o_err), .i_rdata(o_rdata),
		.o_req(i_req), .o_write(i_write), .o_addr(i_addr), .o_wdata(i_wdata));
	task automatic chk(input logic [15:0] g, x);
		tests_run++;
		if (g !== x) begin
			fail_count++;
			$display("FAIL t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, d, x, input logic [1:0] xe);
		u_net_master.xfer(w, a, d, r, e);
		chk({14'h0, e}, {14'h0, xe});
		if (!w && xe == 2'h2) chk(r, x);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial forever #50 i_clock = ~i_clock;
	initial begin
		i_base_inputs <= 12'ha5c;
		i_exp_inputs <= {480'h0, 32'hbeef1234};
		i_exp_in_count <= 6'h2;
		i_exp_out_count <= 5'h1;
		repeat (20) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		repeat (3) @(posedge i_clock);
		acc(1'b0, 16'h0, 16'h0, 16'h0a5c, 2'h2);
		acc(1'b0, 16'h1, 16'h0, 16'h1234, 2'h2);
		acc(1'b0, 16'h2, 16'h0, 16'hbeef, 2'h2);
		acc(1'b0, 16'h3, 16'h0, 16'h0, 2'h3);
		acc(1'b1, 16'h0, 16'h5555, 16'h0, 2'h3);
		acc(1'b0, 16'h32, 16'h0, 16'h0, 2'h3);
		acc(1'b1, 16'h64, 16'hffff, 16'h0, 2'h2);
		chk({4'h0, o_base_outputs}, 16'h0fff);
		acc(1'b0, 16'h64, 16'h0, 16'h0fff, 2'h2);
		acc(1'b1, 16'h65, 16'hc3c3, 16'h0, 2'h2);
		chk(o_exp_outputs[15:0], 16'hc3c3);
		acc(1'b0, 16'h65, 16'h0, 16'hc3c3, 2'h2);
		acc(1'b1, 16'h66, 16'h1111, 16'h0, 2'h3);
		chk(o_exp_outputs[31:16], 16'h0);
		acc(1'b0, 16'h81, 16'h0, 16'h0, 2'h3);
		i_exp_in_count <= 6'h20;
		i_exp_out_count <= 5'h1c;
		i_exp_inputs[511:496] <= 16'h7e81;
		repeat (6) @(posedge i_clock);
		acc(1'b0, 16'h20, 16'h0, 16'h7e81, 2'h2);
		acc(1'b1, 16'h80, 16'h9696, 16'h0, 2'h2);
		chk(o_exp_outputs[447:432], 16'h9696);
		acc(1'b0, 16'h80, 16'h0, 16'h9696, 2'h2);
		acc(1'b0, 16'h21, 16'h0, 16'h0, 2'h3);
		i_sys_rst <= 1'b1;
		repeat (3) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		repeat (5) @(posedge i_clock);
		chk({4'h0, o_base_outputs}, 16'h0);
		chk(o_exp_outputs[15:0], 16'h0);
		acc(1'b0, 16'h64, 16'h0, 16'h0, 2'h2);
		acc(1'b0, 16'h65, 16'h0, 16'h0, 2'h2);
		conclude();
	end
	initial begin
		#30000;
		fail_count++;
		conclude();
	end
endmodule
bind island_io_image_registers island_checker u_island_checker (.i_clock, .i_sys_rst, .i_req,
	.i_write, .i_addr, .i_wdata, .o_ack, .o_err, .o_rdata, .o_base_outputs);
